/* File: logic/mbrm_defines.svh */
`ifndef MBRM_DEFINES_SVH
`define MBRM_DEFINES_SVH
// register byte offsets on the avalon slave
`define MBRM_OFF_CTRL 8'h00
`define MBRM_OFF_SERCFG 8'h04
`define MBRM_OFF_KIND 8'h08
`define MBRM_OFF_ADDR 8'h0c
`define MBRM_OFF_QTY 8'h10
`define MBRM_OFF_RESPTO 8'h14
`define MBRM_OFF_GAPTO 8'h18
`define MBRM_OFF_STATUS 8'h1c
`define MBRM_OFF_IRQST 8'h20
`define MBRM_OFF_IRQMSK 8'h24
`define MBRM_OFF_PACK 8'h28
`define MBRM_OFF_ADDR2 8'h2c
// ctrl fields
`define MBRM_CTRL_GO 0
`define MBRM_CTRL_POLL 1
`define MBRM_CTRL_ABORT 2
// interrupt status bits
`define MBRM_IRQ_DONE 0
`define MBRM_IRQ_TMO 1
`define MBRM_IRQ_ERR 2
`define MBRM_IRQ_EXC 3
// timing
`define MBRM_CLK_HZ 250000000
`define MBRM_BAUD_DEF 19200
`define MBRM_DIV_DEF (`MBRM_CLK_HZ / `MBRM_BAUD_DEF)
`define MBRM_RESP_TO_MS 3000
`define MBRM_RESP_TO_CYC (`MBRM_RESP_TO_MS * (`MBRM_CLK_HZ / 1000))
`define MBRM_GAP_CHAR_X10 15
`define MBRM_GAP_CYC (`MBRM_GAP_CHAR_X10 * 11 * `MBRM_DIV_DEF / 10)
`define MBRM_MAX_BATCH 64
`define MBRM_STATION_DEF 8'h01
`endif

/* File: logic/mbrm_pkg.sv */
package mbrm_pkg;
  typedef enum logic [2:0] {
    MBRM_RD_COILS = 3'h0,
    MBRM_RD_INPUTS = 3'h1,
    MBRM_RD_HOLD = 3'h2,
    MBRM_RD_INREG = 3'h3,
    MBRM_WR_BITS = 3'h4,
    MBRM_WR_WORDS = 3'h5
  } mbrm_kind_t;
  typedef enum logic [3:0] {
    MBRM_IDLE = 4'h1,
    MBRM_SEND = 4'h2,
    MBRM_WAIT = 4'h4,
    MBRM_RECV = 4'h8
  } mbrm_state_t;
  typedef struct packed {
    mbrm_kind_t kind;
    logic [7:0] station;
    logic [15:0] addr;
    logic [15:0] qty;
  } mbrm_req_t;
  typedef struct packed {
    logic stop2;
    logic [1:0] parity;
    logic [17:0] div;
  } mbrm_ser_t;
endpackage

/* File: logic/mbrm_poller.sv */
// The register addresses and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "mbrm_defines.svh"
module mbrm_poller #(
  parameter int unsigned RESP_TO_CYC = `MBRM_RESP_TO_CYC,
  parameter int unsigned GAP_CYC = `MBRM_GAP_CYC,
  parameter int unsigned MAX_BATCH = `MBRM_MAX_BATCH,
  parameter int unsigned TXB_DEPTH = 16,
  parameter int unsigned RXB_DEPTH = 32
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic CE,
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  output logic IRQ,
  output logic TXD,
  output logic TXD_OE,
  input wire logic RXD
);
  localparam int TW = $clog2(TXB_DEPTH);
  localparam int RW = $clog2(RXB_DEPTH);

  function automatic logic [15:0] crc_upd(input logic [15:0] c,
                                          input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ 16'ha001) : (r >> 1);
    end
    return r;
  endfunction

  mbrm_pkg::mbrm_state_t state;
  mbrm_pkg::mbrm_req_t req;
  mbrm_pkg::mbrm_ser_t ser;
  logic poll;
  logic [31:0] resp_to, gap_to, rsp_cnt, gap_cnt;
  logic [7:0] pack_gap;
  logic [3:0] irq_st, irq_mask;
  logic [7:0] txb [TXB_DEPTH];
  logic [7:0] rxb [RXB_DEPTH];
  logic [7:0] idx;
  logic [RW:0] rx_len;
  logic [15:0] crc_tx, crc_rx;
  logic [11:0] tx_sh;
  logic [3:0] tx_bits, rx_bits;
  logic [17:0] tx_cnt, rx_cnt;
  logic tx_busy, rx_busy, rx_done, rx_bad;
  logic [10:0] rx_sh;

  // bus decode: one wait cycle, then the answer at the waitrequest-low edge
  wire acc = (AVS_READ | AVS_WRITE) & AVS_WAITREQUEST & CE;
  wire wr = AVS_WRITE & ~AVS_WAITREQUEST & CE;
  wire [31:0] wd = AVS_WRITEDATA;
  wire sel_txb = AVS_ADDRESS[7:6] == 2'b01;
  wire sel_rxb = AVS_ADDRESS[7];
  wire wr_ctrl = wr & (AVS_ADDRESS == `MBRM_OFF_CTRL);
  wire wr_irq = wr & (AVS_ADDRESS == `MBRM_OFF_IRQST);
  wire go = wr_ctrl & wd[`MBRM_CTRL_GO];
  wire abort = wr_ctrl & wd[`MBRM_CTRL_ABORT];
  wire [TW-1:0] txb_i = AVS_ADDRESS[TW+1:2];
  wire [RW-1:0] rxb_i = AVS_ADDRESS[RW+1:2];

  // reference merge arithmetic
  wire [16:0] end_ref = {1'b0, req.addr} + {1'b0, req.qty};
  wire [16:0] a2 = {1'b0, wd[15:0]};
  wire [16:0] merged = a2 - {1'b0, req.addr} + 17'h00001;
  wire merge_ok = (a2 >= end_ref) && ((a2 - end_ref) <= {9'h000, pack_gap})
                  && (merged <= 17'(MAX_BATCH));

  // frame content selection
  wire multi = req.qty > 16'h0001;
  wire is_bit_wr = req.kind == mbrm_pkg::MBRM_WR_BITS;
  wire is_word_wr = req.kind == mbrm_pkg::MBRM_WR_WORDS;
  wire multi_wr = multi & (is_bit_wr | is_word_wr);
  wire [15:0] pdu_addr = req.addr - 16'h0001;
  wire [15:0] bits_bc = (req.qty + 16'h0007) >> 3;
  wire [7:0] bc = is_bit_wr ? bits_bc[7:0] : {req.qty[6:0], 1'b0};
  wire [7:0] body_len = multi_wr ? bc + 8'h07 : 8'h06;
  logic [7:0] fc, body_byte;
  always_comb begin
    case (req.kind)
      mbrm_pkg::MBRM_RD_COILS: fc = 8'h01;
      mbrm_pkg::MBRM_RD_INPUTS: fc = 8'h02;
      mbrm_pkg::MBRM_RD_HOLD: fc = 8'h03;
      mbrm_pkg::MBRM_RD_INREG: fc = 8'h04;
      mbrm_pkg::MBRM_WR_BITS: fc = multi ? 8'h0f : 8'h05;
      mbrm_pkg::MBRM_WR_WORDS: fc = multi ? 8'h10 : 8'h06;
      default: fc = 8'h01;
    endcase
  end
  // byte sequence: station, function, address, count (the value for single writes), then byte count and data for multi writes
  always_comb begin
    case (idx)
      8'h00: body_byte = req.station;
      8'h01: body_byte = fc;
      8'h02: body_byte = pdu_addr[15:8];
      8'h03: body_byte = pdu_addr[7:0];
      8'h04: body_byte = multi_wr | ~(is_bit_wr | is_word_wr) ? req.qty[15:8]
                       : is_bit_wr ? {8{txb[0][0]}} : txb[0];
      8'h05: body_byte = multi_wr | ~(is_bit_wr | is_word_wr) ? req.qty[7:0]
                       : is_bit_wr ? 8'h00 : txb[1];
      8'h06: body_byte = bc;
      default: body_byte = txb[TW'(idx - 8'h07)];
    endcase
  end
  // check bytes follow the body, low byte first
  wire [7:0] tx_byte = (idx < body_len) ? body_byte
                     : (idx == body_len) ? crc_tx[7:0] : crc_tx[15:8];
  wire in_send = state == mbrm_pkg::MBRM_SEND;
  wire tx_load = CE & in_send & ~tx_busy & (idx < body_len + 8'h02);
  wire send_end = CE & in_send & ~tx_busy & ~tx_load;
  wire rsp_exp = CE & (state == mbrm_pkg::MBRM_WAIT) & ~rx_busy
                 & (rsp_cnt >= resp_to);
  wire frame_end = CE & (state == mbrm_pkg::MBRM_RECV) & ~rx_busy & ~rx_done
                   & (gap_cnt >= gap_to);
  // a framing error on the closing byte also spoils the reply
  wire rx_ok = (crc_rx == 16'h0000) && (rx_len >= (RW+1)'(5))
               && (rxb[0] == req.station) && ~rx_bad;
  wire good = rx_ok & (rxb[1] == fc);
  wire exc = rx_ok & (rxb[1] == {1'b1, fc[6:0]});
  wire [3:0] ev = {frame_end & exc, frame_end & ~good & ~exc, rsp_exp,
                   frame_end & good};
  wire par_bit = ser.parity[1] ? ~^tx_byte : ^tx_byte;
  wire [3:0] nbits = 4'd10 + {3'd0, |ser.parity} + {3'd0, ser.stop2};
  wire [3:0] rx_nb = 4'd9 + {3'd0, |ser.parity};

  // bus answer: waitrequest drops for exactly one cycle per request
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      AVS_WAITREQUEST <= 1'b1;
    end else if (CE) begin
      AVS_WAITREQUEST <= ~acc;
    end
  end

  // read data mux, captured at the answer
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      AVS_READDATA <= 32'h0000_0000;
    end else if (acc) begin
      case (1'b1)
        sel_rxb: AVS_READDATA <= {24'h0, rxb[rxb_i]};
        sel_txb: AVS_READDATA <= {24'h0, txb[txb_i]};
        AVS_ADDRESS == `MBRM_OFF_CTRL: AVS_READDATA <= {16'h0, req.station,
                                                        6'h0, poll, 1'b0};
        AVS_ADDRESS == `MBRM_OFF_SERCFG: AVS_READDATA <= {11'h0, ser};
        AVS_ADDRESS == `MBRM_OFF_KIND: AVS_READDATA <= {29'h0, req.kind};
        AVS_ADDRESS == `MBRM_OFF_ADDR: AVS_READDATA <= {16'h0, req.addr};
        AVS_ADDRESS == `MBRM_OFF_QTY: AVS_READDATA <= {16'h0, req.qty};
        AVS_ADDRESS == `MBRM_OFF_RESPTO: AVS_READDATA <= resp_to;
        AVS_ADDRESS == `MBRM_OFF_GAPTO: AVS_READDATA <= gap_to;
        AVS_ADDRESS == `MBRM_OFF_STATUS: AVS_READDATA <= {16'h0,
            8'(rx_len), 4'h0, state};
        AVS_ADDRESS == `MBRM_OFF_IRQST: AVS_READDATA <= {28'h0, irq_st};
        AVS_ADDRESS == `MBRM_OFF_IRQMSK: AVS_READDATA <= {28'h0, irq_mask};
        AVS_ADDRESS == `MBRM_OFF_PACK: AVS_READDATA <= {24'h0, pack_gap};
        default: AVS_READDATA <= 32'h0000_0000;
      endcase
    end
  end

  // configuration registers
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      req <= '{mbrm_pkg::MBRM_RD_COILS, `MBRM_STATION_DEF, 16'h0001,
               16'h0001};
      ser <= '{1'b0, 2'b00, 18'(`MBRM_DIV_DEF)};
      poll <= 1'b0;
      resp_to <= RESP_TO_CYC;
      gap_to <= GAP_CYC;
      pack_gap <= 8'h00;
      irq_mask <= 4'h0;
    end else if (wr) begin
      if (wr_ctrl) begin
        poll <= wd[`MBRM_CTRL_POLL];
        req.station <= wd[15:8];
      end
      case (AVS_ADDRESS)
        `MBRM_OFF_SERCFG: ser <= wd[20:0];
        `MBRM_OFF_KIND: req.kind <= mbrm_pkg::mbrm_kind_t'(wd[2:0]);
        `MBRM_OFF_ADDR: req.addr <= wd[15:0];
        `MBRM_OFF_QTY: req.qty <= wd[15:0];
        `MBRM_OFF_RESPTO: resp_to <= wd;
        `MBRM_OFF_GAPTO: gap_to <= wd;
        `MBRM_OFF_IRQMSK: irq_mask <= wd[3:0];
        // interval kept below the largest batch
        `MBRM_OFF_PACK: pack_gap <= (wd[7:0] < 8'(MAX_BATCH)) ? wd[7:0]
                                    : 8'(MAX_BATCH - 1);
        `MBRM_OFF_ADDR2: if (merge_ok) req.qty <= merged[15:0];
        default: ;
      endcase
    end
  end

  // buffer stores
  always_ff @(posedge CLK) begin
    if (wr & sel_txb) txb[txb_i] <= wd[7:0];
    // bytes past the buffer are dropped so the station byte survives
    if (CE & rx_done & ~rx_len[RW] & (state == mbrm_pkg::MBRM_RECV)) begin
      rxb[rx_len[RW-1:0]] <= rx_sh[8:1];
    end
  end

  // sticky events, set wins over a write-one clear
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      irq_st <= 4'h0;
      IRQ <= 1'b0;
    end else if (CE) begin
      irq_st <= (irq_st & ~(wr_irq ? wd[3:0] : 4'h0)) | ev;
      IRQ <= |(irq_st & irq_mask);
    end
  end

  // exchange sequencer
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      state <= mbrm_pkg::MBRM_IDLE;
      idx <= 8'h00;
      crc_tx <= 16'hffff;
      crc_rx <= 16'hffff;
      rsp_cnt <= 32'h0;
      rx_len <= '0;
      TXD_OE <= 1'b0;
    end else if (CE) begin
      TXD_OE <= in_send;
      if (tx_load) begin
        idx <= idx + 8'h01;
        if (idx < body_len) crc_tx <= crc_upd(crc_tx, tx_byte);
      end
      rsp_cnt <= (state == mbrm_pkg::MBRM_WAIT) ? rsp_cnt + 32'h1 : 32'h0;
      if (rx_done & (state == mbrm_pkg::MBRM_RECV)) begin
        crc_rx <= crc_upd(crc_rx, rx_sh[8:1]);
        if (rx_len < (RW+1)'(RXB_DEPTH)) rx_len <= rx_len + 1'b1;
      end
      case (state)
        // only a software start leaves idle
        mbrm_pkg::MBRM_IDLE: if (go) begin
          state <= mbrm_pkg::MBRM_SEND;
          idx <= 8'h00;
          crc_tx <= 16'hffff;
        end
        mbrm_pkg::MBRM_SEND: if (send_end) begin
          state <= mbrm_pkg::MBRM_WAIT;
          rx_len <= '0;
          crc_rx <= 16'hffff;
        end
        mbrm_pkg::MBRM_WAIT: if (rx_busy) begin
          state <= mbrm_pkg::MBRM_RECV;
        end else if (rsp_exp) begin
          state <= mbrm_pkg::MBRM_SEND;
          idx <= 8'h00;
          crc_tx <= 16'hffff;
        end
        mbrm_pkg::MBRM_RECV: if (frame_end) begin
          state <= (poll | ~good) ? mbrm_pkg::MBRM_SEND
                   : mbrm_pkg::MBRM_IDLE;
          idx <= 8'h00;
          crc_tx <= 16'hffff;
        end
        default: state <= mbrm_pkg::MBRM_IDLE;
      endcase
      if (abort) state <= mbrm_pkg::MBRM_IDLE;
    end
  end

  // transmitter: start, eight data bits, parity when enabled, one or two stops
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      tx_sh <= 12'hfff;
      tx_busy <= 1'b0;
      tx_bits <= 4'h0;
      tx_cnt <= 18'h0;
    end else if (CE) begin
      if (tx_load) begin
        tx_sh <= {2'b11, |ser.parity ? par_bit : 1'b1, tx_byte, 1'b0};
        tx_busy <= 1'b1;
        tx_bits <= nbits;
        tx_cnt <= ser.div;
      end else if (tx_busy) begin
        tx_cnt <= (tx_cnt == 18'h1) ? ser.div : tx_cnt - 18'h1;
        if (tx_cnt == 18'h1) begin
          tx_sh <= {1'b1, tx_sh[11:1]};
          tx_bits <= tx_bits - 4'h1;
          tx_busy <= tx_bits != 4'h1;
        end
      end
    end
  end
  assign TXD = tx_sh[0];

  // receiver samples mid-bit; gap counter runs while the line rests
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      rx_busy <= 1'b0;
      rx_done <= 1'b0;
      rx_bad <= 1'b0;
      rx_sh <= 11'h0;
      rx_bits <= 4'h0;
      rx_cnt <= 18'h0;
      gap_cnt <= 32'h0;
    end else if (CE) begin
      rx_done <= 1'b0;
      gap_cnt <= rx_busy ? 32'h0 : gap_cnt + 32'h1;
      if (~rx_busy & ~RXD) begin
        rx_busy <= 1'b1;
        rx_cnt <= {1'b0, ser.div[17:1]};
        rx_bits <= rx_nb;
      end else if (rx_busy) begin
        rx_cnt <= (rx_cnt == 18'h1) ? ser.div : rx_cnt - 18'h1;
        if (rx_cnt == 18'h1) begin
          // start lands in bit 0, data in bits 8:1, then parity when enabled, and stop
          rx_sh[rx_nb - rx_bits] <= RXD;
          rx_bits <= rx_bits - 4'h1;
          if (rx_bits == 4'h0) begin
            rx_busy <= 1'b0;
            rx_done <= RXD;
            rx_bad <= ~RXD;
          end
        end
      end
    end
  end

  // checks
  chk_station_first: assert property (@(posedge CLK) disable iff (RESET)
    tx_load && idx == 8'h00 |-> tx_byte == req.station)
    else $error("first byte is not the station");
  chk_fc_second: assert property (@(posedge CLK) disable iff (RESET)
    tx_load && idx == 8'h01 |-> tx_byte == fc)
    else $error("second byte is not the function");
  chk_words_fc: assert property (@(posedge CLK) disable iff (RESET)
    tx_load && idx == 8'h01 && is_word_wr && multi |-> tx_byte == 8'h10)
    else $error("multi word write not 0x10");
  chk_bits_fc: assert property (@(posedge CLK) disable iff (RESET)
    tx_load && idx == 8'h01 && is_bit_wr && multi |-> tx_byte == 8'h0f)
    else $error("multi bit write not 0x0f");
  chk_addr_minus: assert property (@(posedge CLK) disable iff (RESET)
    tx_load && idx == 8'h03 |-> tx_byte == 8'(req.addr - 16'h1))
    else $error("address low byte wrong");
  chk_crc_low: assert property (@(posedge CLK) disable iff (RESET)
    tx_load && idx == body_len |-> tx_byte == crc_tx[7:0])
    else $error("check low byte not first");
  chk_timeout_resend: assert property (@(posedge CLK) disable iff (RESET)
    rsp_exp && !abort |=> in_send && irq_st[`MBRM_IRQ_TMO] && idx == 8'h00)
    else $error("timeout did not resend");
  chk_poll_repeat: assert property (@(posedge CLK) disable iff (RESET)
    frame_end && poll && !abort |=> in_send)
    else $error("polling stopped");
  chk_idle_silent: assert property (@(posedge CLK) disable iff (RESET)
    state == mbrm_pkg::MBRM_IDLE && !go |=> !in_send ##1 !TXD_OE)
    else $error("frame sent without a start");
  chk_bus_answer: assert property (@(posedge CLK) disable iff (RESET)
    acc |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
    else $error("bus answer not one cycle");
  cov_good_reply: cover property (@(posedge CLK) disable iff (RESET)
    frame_end && good);
  cov_timeout: cover property (@(posedge CLK) disable iff (RESET) rsp_exp);
  cov_multi_write: cover property (@(posedge CLK) disable iff (RESET)
    tx_load && multi_wr && idx == 8'h06);
endmodule
`default_nettype wire

/* File: verification/mbrm_slave_model.sv */
`timescale 1ns/1ps
`default_nettype none
// serial slave stand-in: captures each request and answers it unless muted or its crc is wrong
module mbrm_slave_model #(
  parameter int DIV = 20
) (
  input wire logic clk,
  input wire logic txd,
  input wire logic mute,
  output logic rxd
);
  logic [7:0] fb [0:63];
  logic [7:0] ab [0:63];
  int flen;
  int nframes;
  // reflected crc16, init ffff
  function automatic logic [15:0] crc16(input logic [7:0] m [0:63],
                                        input int n);
    logic [15:0] c;
    c = 16'hffff;
    for (int i = 0; i < n; i++) begin
      c = c ^ {8'h00, m[i]};
      for (int j = 0; j < 8; j++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    return c;
  endfunction
  // sample one byte from its start edge, lsb first, 8n1
  task automatic rx_byte(output logic [7:0] b);
    repeat (DIV / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (DIV) @(posedge clk);
      b[i] = txd;
    end
    repeat (DIV) @(posedge clk);
  endtask
  // send one byte with the same framing as the master
  task automatic tx_byte(input logic [7:0] b);
    rxd <= 1'b0;
    repeat (DIV) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      rxd <= b[i];
      repeat (DIV) @(posedge clk);
    end
    rxd <= 1'b1;
    repeat (DIV) @(posedge clk);
  endtask
  // a frame ends once the line rests 30 bit times; then reply
  initial begin : serve
    logic [7:0] b;
    int n;
    int alen;
    logic [15:0] c;
    rxd = 1'b1;
    nframes = 0;
    flen = 0;
    forever begin
      @(negedge txd);
      flen = 0;
      do begin
        rx_byte(b);
        fb[flen] = b;
        flen++;
        n = 0;
        while (txd === 1'b1 && n < 30 * DIV) begin
          @(posedge clk);
          n++;
        end
      end while (n < 30 * DIV);
      nframes++;
      c = crc16(fb, flen - 2);
      if (!mute && {fb[flen-1], fb[flen-2]} == c) begin
        ab[0] = fb[0];
        ab[1] = fb[1];
        if (fb[1] <= 8'h04) begin
          ab[2] = fb[1] <= 8'h02 ? 8'((fb[5] + 7) / 8) : 8'(2 * fb[5]);
          for (int i = 0; i < ab[2]; i++) ab[3+i] = 8'(i) ^ 8'h5a;
          alen = 3 + ab[2];
        end else begin
          for (int i = 2; i < 6; i++) ab[i] = fb[i];
          alen = 6;
        end
        c = crc16(ab, alen);
        ab[alen] = c[7:0];
        ab[alen+1] = c[15:8];
        for (int i = 0; i < alen + 2; i++) tx_byte(ab[i]);
      end
    end
  end
endmodule
`default_nettype wire

/* File: verification/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mbrm_defines.svh"
module testbench;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] addr = 8'h00;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic mute = 1'b0;
  logic [31:0] rdata;
  logic wait_req;
  logic irq;
  logic txd;
  logic txd_oe;
  logic rxd;
  int err_total = 0;
  int checked = 0;
  // 250 mhz clock
  always #2 clk = ~clk;
  mbrm_poller #(.RESP_TO_CYC(5000), .GAP_CYC(400)) i_mbrm_poller (
    .CLK(clk), .RESET(reset), .CE(1'b1), .AVS_ADDRESS(addr),
    .AVS_READ(rd_en), .AVS_WRITE(wr_en), .AVS_WRITEDATA(wdata),
    .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_req), .IRQ(irq),
    .TXD(txd), .TXD_OE(txd_oe), .RXD(rxd));
  mbrm_slave_model #(.DIV(20)) i_mbrm_slave_model (
    .clk(clk), .txd(txd), .mute(mute), .rxd(rxd));
  task summarize;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one avalon access, held until waitrequest is seen low at an edge
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] q);
    int n;
    @(posedge clk);
    addr <= a;
    rd_en <= !w;
    wr_en <= w;
    wdata <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wait_req !== 1'b0 && n < 100);
    if (wait_req !== 1'b0) begin
      err_total++;
      summarize();
    end
    q = rdata;
    rd_en <= 1'b0;
    wr_en <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q, e);
  endtask
  task wait_cond(input int which, input int k);
    int n;
    n = 0;
    while ((which == 0 ? irq !== 1'b1 : i_mbrm_slave_model.nframes < k)
           && n < 40000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 40000) begin
      err_total++;
      summarize();
    end
  endtask
  function automatic logic [7:0] fb(input int i);
    return i_mbrm_slave_model.fb[i];
  endfunction
  // header and trailing crc of the last captured request
  task chk_frame(input logic [7:0] fc, input logic [15:0] a,
                 input logic [15:0] q);
    logic [15:0] c;
    int n;
    n = i_mbrm_slave_model.flen;
    c = i_mbrm_slave_model.crc16(i_mbrm_slave_model.fb, n - 2);
    check({fb(0), fb(1)}, {8'h01, fc});
    check({fb(2), fb(3), fb(4), fb(5)}, {a, q});
    check({fb(n - 2), fb(n - 1)}, {c[7:0], c[15:8]});
  endtask
  task start(input logic [2:0] k, input logic [15:0] a,
             input logic [15:0] q, input logic [31:0] ctl);
    wr(`MBRM_OFF_KIND, {29'h0, k});
    wr(`MBRM_OFF_ADDR, {16'h0, a});
    wr(`MBRM_OFF_QTY, {16'h0, q});
    wr(`MBRM_OFF_CTRL, ctl);
  endtask
  task done_clear;
    wait_cond(0, 0);
    rd_chk(`MBRM_OFF_IRQST, 32'h1);
    wr(`MBRM_OFF_IRQST, 32'h1);
    repeat (3) @(negedge clk);
    check({31'h0, irq}, 32'h0);
  endtask
  task t_reset;
    check({29'h0, txd, txd_oe, irq}, 32'h4);
    rd_chk(`MBRM_OFF_SERCFG, 32'(`MBRM_DIV_DEF));
    rd_chk(8'h30, 32'h0);
    repeat (2000) @(posedge clk);
    check(i_mbrm_slave_model.nframes, 0);
    wr(`MBRM_OFF_SERCFG, 32'h14);
    wr(`MBRM_OFF_RESPTO, 32'd5000);
    wr(`MBRM_OFF_GAPTO, 32'd400);
    wr(`MBRM_OFF_IRQMSK, 32'hf);
  endtask
  // interval clamp and merge of a nearby reference into the count
  task t_merge;
    wr(`MBRM_OFF_PACK, 32'hff);
    rd_chk(`MBRM_OFF_PACK, 32'(`MBRM_MAX_BATCH - 1));
    wr(`MBRM_OFF_PACK, 32'h0a);
    wr(`MBRM_OFF_ADDR, 32'd20);
    wr(`MBRM_OFF_QTY, 32'd5);
    wr(`MBRM_OFF_ADDR2, 32'd30);
    rd_chk(`MBRM_OFF_QTY, 32'd11);
    wr(`MBRM_OFF_ADDR2, 32'd100);
    rd_chk(`MBRM_OFF_QTY, 32'd11);
  endtask
  task t_reads;
    for (int k = 0; k < 4; k++) begin
      start(3'(k), 16'd20, 16'd5, 32'h0101);
      done_clear();
      chk_frame(8'(k + 1), 16'h0013, 16'h0005);
      rd_chk(8'h88, k < 2 ? 32'h1 : 32'ha);
    end
  endtask
  task t_write(input logic [2:0] k, input logic [15:0] a,
               input logic [15:0] q, input logic [7:0] fc,
               input logic [15:0] w45, input logic [7:0] bc);
    start(k, a, q, 32'h0101);
    done_clear();
    chk_frame(fc, a - 16'h1, w45);
    if (bc != 8'h00)
      check({fb(6), fb(7), fb(8)}, {bc, 16'h1122});
  endtask
  task t_writes;
    for (int i = 0; i < 6; i++) wr(8'(8'h40 + 4 * i), 32'(8'h11 * (i + 1)));
    t_write(3'h5, 16'd10, 16'd3, 8'h10, 16'h3, 8'h06);
    t_write(3'h4, 16'd10, 16'd10, 8'h0f, 16'ha, 8'h02);
    t_write(3'h4, 16'hffff, 16'd1, 8'h05, 16'hff00, 8'h00);
    t_write(3'h5, 16'd1, 16'd1, 8'h06, 16'h1122, 8'h00);
  endtask
  task t_timeout;
    int n0;
    mute = 1'b1;
    wr(`MBRM_OFF_IRQMSK, 32'h1);
    n0 = i_mbrm_slave_model.nframes;
    start(3'h2, 16'd1, 16'd1, 32'h0101);
    wait_cond(1, n0 + 2);
    check({31'h0, irq}, 32'h0);
    rd_chk(`MBRM_OFF_IRQST, 32'h2);
    chk_frame(8'h03, 16'h0, 16'h1);
    wr(`MBRM_OFF_CTRL, 32'h0104);
    wr(`MBRM_OFF_IRQST, 32'hf);
    mute = 1'b0;
    repeat (3000) @(posedge clk);
    wr(`MBRM_OFF_IRQMSK, 32'hf);
  endtask
  task t_poll;
    int n0;
    int n1;
    n0 = i_mbrm_slave_model.nframes;
    start(3'h0, 16'd20, 16'd5, 32'h0103);
    wait_cond(1, n0 + 3);
    chk_frame(8'h01, 16'h0013, 16'h0005);
    wr(`MBRM_OFF_CTRL, 32'h0104);
    repeat (5000) @(posedge clk);
    n1 = i_mbrm_slave_model.nframes;
    repeat (6000) @(posedge clk);
    check(i_mbrm_slave_model.nframes, n1);
    check({31'h0, txd_oe}, 32'h0);
  endtask
  // whole run under a fixed ceiling
  initial begin
    repeat (100000) @(posedge clk);
    err_total++;
    summarize();
  end
  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    t_reset();
    t_merge();
    t_reads();
    t_writes();
    t_timeout();
    t_poll();
    summarize();
  end
endmodule
`default_nettype wire
